/* eth_rx_watermark_irq.sv */
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module eth_rx_watermark_irq #(
	parameter int LEVEL_WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// MAC side
	input wire logic [LEVEL_WIDTH-1:0] rx_buffer_count,
	input wire eth_wm_pkg::mac_events_s mac_events,
	// Results
	output logic flow_control_on,
	output logic full_level_event,
	output logic empty_level_event,
	output logic irq
);
	import eth_wm_pkg::*;

	logic [LEVEL_WIDTH-1:0] rx_full_level_r;
	logic [LEVEL_WIDTH-1:0] rx_empty_level_r;
	logic [31:0] irq_enable_r;
	logic [31:0] irq_status_r;
	logic [31:0] irq_status_nxt;
	logic auto_fc_r;
	logic [31:0] prdata_r;
	logic at_full;
	logic at_empty;
	logic at_full_q_r;
	logic at_empty_q_r;
	logic fc_active;

	// Decode
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire hit_wm = (paddr == OFF_WATERMARKS);
	wire hit_en = (paddr == OFF_IRQ_ENABLE);
	wire hit_st = (paddr == OFF_IRQ_STATUS);
	wire hit_ctl = (paddr == OFF_CONTROL);
	wire hit_state = (paddr == OFF_STATE);
	wire mapped = hit_wm | hit_en | hit_st | hit_ctl | hit_state;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	level_compare #(
		.W(LEVEL_WIDTH)
	) u_cmp (
		.count(rx_buffer_count),
		.full_level(rx_full_level_r),
		.empty_level(rx_empty_level_r),
		.at_full(at_full),
		.at_empty(at_empty)
	);

	flow_ctrl_fsm u_fc (
		.clk_sys(clk_sys),
		.srst(srst),
		.auto_en(auto_fc_r),
		.at_full(at_full),
		.at_empty(at_empty),
		.fc_active(fc_active)
	);

	// Rising edges of the level conditions raise the sticky events
	wire full_rise = at_full && !at_full_q_r;
	wire empty_rise = at_empty && !at_empty_q_r;

	// Event vector in the enable layout
	wire [31:0] event_vec = {17'h0_0000,
		mac_events.tx_bus_error, mac_events.rx_bus_error, 3'h0,
		empty_rise, full_rise,
		mac_events.rx_complete, mac_events.packet_waiting, mac_events.rx_activity, 1'b0,
		mac_events.tx_complete, mac_events.tx_aborted,
		mac_events.rx_no_descriptor, mac_events.rx_overrun};

	// Set wins over a write-one clear arriving the same cycle
	// Reading clears nothing; only a written one drops a flag
	wire [31:0] clr_vec = (wr && hit_st) ? pwdata : RESET_WORD;
	assign irq_status_nxt = ((irq_status_r & ~clr_vec) | event_vec) & IRQ_IMPL_MASK;

	// Transmit and receive gating both land on the one output line
	wire [31:0] gated = irq_status_r & irq_enable_r;
	wire tx_pending = |(gated & TX_SRC_MASK);
	wire rx_pending = |(gated & ~TX_SRC_MASK);

	wire [31:0] wm_word = ({8'h00, rx_full_level_r, 8'h00, rx_empty_level_r}) & WM_IMPL_MASK;
	wire [31:0] state_word = {29'h0, fc_active, at_empty, at_full};
	wire [31:0] rd_mux = hit_wm ? wm_word :
		hit_en ? irq_enable_r :
		hit_st ? irq_status_r :
		hit_ctl ? {31'h0, auto_fc_r} :
		hit_state ? state_word : RESET_WORD;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_full_level_r <= '0;
			rx_empty_level_r <= '0;
		end else if (wr && hit_wm) begin
			rx_full_level_r <= pwdata[FULL_LSB +: LEVEL_W];
			rx_empty_level_r <= pwdata[EMPTY_LSB +: LEVEL_W];
		end
	end

	// Only implemented enable bits are stored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_enable_r <= RESET_WORD;
		end else if (wr && hit_en) begin
			irq_enable_r <= pwdata & IRQ_IMPL_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			auto_fc_r <= 1'b0;
		end else if (wr && hit_ctl) begin
			auto_fc_r <= pwdata[B_AUTO_FC];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_status_r <= RESET_WORD;
			// High so a level already met at release raises no event
			at_full_q_r <= 1'b1;
			at_empty_q_r <= 1'b1;
		end else begin
			irq_status_r <= irq_status_nxt;
			at_full_q_r <= at_full;
			at_empty_q_r <= at_empty;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prdata_r <= RESET_WORD;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	// Read data latched in setup so it stays stable through access
	assign prdata = rd ? prdata_r : RESET_WORD;
	assign flow_control_on = fc_active;
	assign full_level_event = irq_status_r[B_FULL_LVL];
	assign empty_level_event = irq_status_r[B_EMPTY_LVL];
	assign irq = tx_pending | rx_pending;

	// Assertions
	full_cond_a: assert property (@(posedge clk_sys) disable iff (srst)
		(rx_buffer_count >= rx_full_level_r) && !$past(at_full) |=> full_level_event)
		else $error("full level event missing");
	empty_cond_a: assert property (@(posedge clk_sys) disable iff (srst)
		(rx_buffer_count <= rx_empty_level_r) && !$past(at_empty) |=> empty_level_event)
		else $error("empty level event missing");
	fc_on_a: assert property (@(posedge clk_sys) disable iff (srst)
		auto_fc_r && at_full && !flow_control_on |=> flow_control_on)
		else $error("flow control not enabled");
	fc_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		auto_fc_r && at_empty && flow_control_on |=> !flow_control_on)
		else $error("flow control not disabled");
	fc_manual_a: assert property (@(posedge clk_sys) disable iff (srst)
		!auto_fc_r |=> !flow_control_on)
		else $error("flow control without auto mode");
	wm_gaps_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && hit_wm |-> (prdata & ~WM_IMPL_MASK) == RESET_WORD)
		else $error("watermark reserved bits set");
	en_unimpl_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && hit_en |-> (prdata & ~IRQ_IMPL_MASK) == RESET_WORD)
		else $error("unimplemented enable bit set");
	tx_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
		mac_events.tx_bus_error && irq_enable_r[B_TX_BUS_ERR] |=> irq)
		else $error("tx bus error not raised");
	rx_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
		mac_events.rx_overrun && irq_enable_r[B_RX_OVERRUN] |=> irq)
		else $error("rx overrun not raised");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
		irq == ((irq_status_r & irq_enable_r) != RESET_WORD))
		else $error("irq mismatch");
	set_wins_a: assert property (@(posedge clk_sys) disable iff (srst)
		mac_events.rx_complete |=> irq_status_r[B_RX_DONE])
		else $error("event lost to clear");
	done_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
		mac_events.tx_complete && irq_enable_r[B_TX_DONE] |=> irq)
		else $error("tx done not raised");
	wm_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
		(irq_status_r[B_FULL_LVL] && irq_enable_r[B_FULL_LVL])
		|| (irq_status_r[B_EMPTY_LVL] && irq_enable_r[B_EMPTY_LVL]) |-> irq)
		else $error("enabled level event without irq");
	fc_cycle_c: cover property (@(posedge clk_sys) disable iff (srst)
		!flow_control_on ##1 flow_control_on ##[1:50] !flow_control_on);
	irq_c: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));
	clear_c: cover property (@(posedge clk_sys) disable iff (srst) wr && hit_st && irq);
	set_wins_c: cover property (@(posedge clk_sys) disable iff (srst)
		wr && hit_st && (pwdata & event_vec) != RESET_WORD);
	level_c: cover property (@(posedge clk_sys) disable iff (srst) full_rise ##[1:200] empty_rise);

	// Flow control follows the two levels only in auto mode
	fc_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		auto_fc_r && flow_control_on && !at_empty |=> flow_control_on)
		else $error("flow control dropped early");
	fc_stay_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		!flow_control_on && !(auto_fc_r && at_full) |=> !flow_control_on)
		else $error("flow control raised early");
	fc_rise_a: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(flow_control_on) |-> $past(auto_fc_r) && $past(at_full))
		else $error("flow control rose without cause");
	fc_fall_a: assert property (@(posedge clk_sys) disable iff (srst)
		$fell(flow_control_on) |-> $past(srst) || !$past(auto_fc_r) || $past(at_empty))
		else $error("flow control fell without cause");
	auto_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		wr && hit_ctl |=> auto_fc_r == $past(pwdata[B_AUTO_FC]))
		else $error("auto mode write lost");

	// Level events only on a fresh crossing
	full_rise_a: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(full_level_event) |-> $past(rx_buffer_count >= rx_full_level_r))
		else $error("full event without full level");
	empty_rise_a: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(empty_level_event) |-> $past(rx_buffer_count <= rx_empty_level_r))
		else $error("empty event without empty level");

	// Register writes land and reads return them
	full_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		wr && hit_wm |=> rx_full_level_r == $past(pwdata[FULL_LSB +: LEVEL_W]))
		else $error("full level write lost");
	empty_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		wr && hit_wm |=> rx_empty_level_r == $past(pwdata[EMPTY_LSB +: LEVEL_W]))
		else $error("empty level write lost");
	full_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && hit_wm |-> prdata[FULL_LSB +: LEVEL_W] == rx_full_level_r)
		else $error("full level read wrong");
	empty_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && hit_wm |-> prdata[EMPTY_LSB +: LEVEL_W] == rx_empty_level_r)
		else $error("empty level read wrong");
	en_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && hit_en |-> prdata == irq_enable_r)
		else $error("enable read wrong");
	unmapped_a: assert property (@(posedge clk_sys) disable iff (srst)
		rd && !mapped |-> pslverr && prdata == RESET_WORD)
		else $error("unmapped read not refused");
	idle_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		!rd |-> prdata == RESET_WORD)
		else $error("read data outside read access");

	// Transmit and receive sources reach the one line alike
	tx_side_a: assert property (@(posedge clk_sys) disable iff (srst)
		(irq_status_r & irq_enable_r & TX_SRC_MASK) != RESET_WORD |-> irq)
		else $error("transmit source without irq");
	rx_side_a: assert property (@(posedge clk_sys) disable iff (srst)
		(irq_status_r & irq_enable_r & ~TX_SRC_MASK) != RESET_WORD |-> irq)
		else $error("receive source without irq");

	// Per-source checks; unimplemented bits have none
	for (genvar b = 0; b < $bits(irq_status_r); b++) begin : g_src
		if (IRQ_IMPL_MASK[b]) begin : g_impl
			src_set_a: assert property (@(posedge clk_sys) disable iff (srst)
				event_vec[b] |=> irq_status_r[b])
				else $error("source flag not set");
			src_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
				irq_status_r[b] && !(wr && hit_st && pwdata[b]) |=> irq_status_r[b])
				else $error("source flag dropped");
			src_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
				wr && hit_st && pwdata[b] && !event_vec[b] |=> !irq_status_r[b])
				else $error("source flag not cleared");
			src_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
				irq_status_r[b] && irq_enable_r[b] |-> irq)
				else $error("enabled source without irq");
			src_masked_a: assert property (@(posedge clk_sys) disable iff (srst)
				(irq_status_r & irq_enable_r) == RESET_WORD |-> !irq)
				else $error("irq without enabled source");
			en_write_a: assert property (@(posedge clk_sys) disable iff (srst)
				wr && hit_en |=> irq_enable_r[b] == $past(pwdata[b]))
				else $error("enable write lost");
		end
	end
endmodule : eth_rx_watermark_irq

/* eth_wm_pkg.sv */
package eth_wm_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_WATERMARKS = 8'h00;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_STATE = 8'h10;
	// Watermark field positions
	localparam int FULL_LSB = 16;
	localparam int EMPTY_LSB = 0;
	localparam int LEVEL_W = 8;
	// Interrupt source bit positions, shared by enable and status
	localparam int B_TX_BUS_ERR = 14;
	localparam int B_RX_BUS_ERR = 13;
	localparam int B_EMPTY_LVL = 9;
	localparam int B_FULL_LVL = 8;
	localparam int B_RX_DONE = 7;
	localparam int B_PKT_WAIT = 6;
	localparam int B_RX_ACT = 5;
	localparam int B_TX_DONE = 3;
	localparam int B_TX_ABORT = 2;
	localparam int B_RX_NO_DESC = 1;
	localparam int B_RX_OVERRUN = 0;
	localparam logic [31:0] IRQ_IMPL_MASK = 32'h0000_63ef;
	localparam logic [31:0] TX_SRC_MASK = 32'h0000_400c;
	localparam logic [31:0] WM_IMPL_MASK = 32'h00ff_00ff;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// Control register bit
	localparam int B_AUTO_FC = 0;

	typedef struct packed {
		logic tx_bus_error;
		logic rx_bus_error;
		logic rx_complete;
		logic packet_waiting;
		logic rx_activity;
		logic tx_complete;
		logic tx_aborted;
		logic rx_no_descriptor;
		logic rx_overrun;
	} mac_events_s;

	typedef enum logic {
		FC_OFF,
		FC_ON
	} fc_state_e;
endpackage : eth_wm_pkg

/* level_compare.sv */
`timescale 1ns/1ps
module level_compare #(
	parameter int W = 8
) (
	// Operands
	input wire logic [W-1:0] count,
	input wire logic [W-1:0] full_level,
	input wire logic [W-1:0] empty_level,
	// Conditions
	output logic at_full,
	output logic at_empty
);
	assign at_full = count >= full_level;
	assign at_empty = count <= empty_level;
endmodule : level_compare

/* flow_ctrl_fsm.sv */
`timescale 1ns/1ps
module flow_ctrl_fsm (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Conditions
	input wire logic auto_en,
	input wire logic at_full,
	input wire logic at_empty,
	// Result
	output logic fc_active
);
	import eth_wm_pkg::*;
	fc_state_e state_r;
	fc_state_e state_nxt;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			FC_OFF: begin
				if (auto_en && at_full) begin
					state_nxt = FC_ON;
				end
			end
			FC_ON: begin
				// Leaving auto mode or reaching the empty level releases flow control
				if (!auto_en || at_empty) begin
					state_nxt = FC_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_r <= FC_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign fc_active = (state_r == FC_ON);
endmodule : flow_ctrl_fsm

/* tb.sv */
`timescale 1ns/1ps
module tb;
	import eth_wm_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] cnt = 8'h00;
	mac_events_s ev = '0;
	logic fc_on;
	logic full_ev;
	logic empty_ev;
	logic irq;
	logic [31:0] q;
	logic e;
	int failures = 0;
	int cmp_count = 0;
	// Status bit of each event, in struct order, msb first
	int pos [9] = '{14, 13, 7, 6, 5, 3, 2, 1, 0};

	always #25 clk_sys = ~clk_sys;

	eth_rx_watermark_irq #(.LEVEL_WIDTH(8)) DUT (
		.clk_sys(clk_sys),
		.srst(srst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rx_buffer_count(cnt),
		.mac_events(ev),
		.flow_control_on(fc_on),
		.full_level_event(full_ev),
		.empty_level_event(empty_ev),
		.irq(irq)
	);

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Slave may stretch the access; bounded wait guards a stuck pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			give_verdict();
		end
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0000_0000);
		check(name, q, exp);
	endtask : rd

	task automatic pulse(input int i);
		@(posedge clk_sys);
		ev <= mac_events_s'(9'h001 << i);
		@(posedge clk_sys);
		ev <= '0;
		@(negedge clk_sys);
	endtask : pulse

	task automatic set_cnt(input logic [7:0] v);
		@(posedge clk_sys);
		cnt <= v;
		repeat (3) @(negedge clk_sys);
	endtask : set_cnt

	initial begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		rd(OFF_WATERMARKS, RESET_WORD, "levels reset");
		rd(OFF_IRQ_ENABLE, RESET_WORD, "enable reset");
		// Full kept above empty even for the gap check
		apb(1'b1, OFF_WATERMARKS, 32'hffff_fffe);
		rd(OFF_WATERMARKS, 32'h00ff_00fe, "levels gaps");
		apb(1'b1, OFF_IRQ_ENABLE, 32'hffff_ffff);
		rd(OFF_IRQ_ENABLE, IRQ_IMPL_MASK, "enable gaps");
		// Every other source enabled, so a swapped bit shows up
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, OFF_IRQ_ENABLE, IRQ_IMPL_MASK & ~(32'h1 << pos[8-i]));
			pulse(i);
			check("irq masked", 32'(irq), 32'h0);
			rd(OFF_IRQ_STATUS, 32'h1 << pos[8-i], "event status");
			apb(1'b1, OFF_IRQ_ENABLE, 32'h1 << pos[8-i]);
			@(negedge clk_sys);
			check("irq enabled", 32'(irq), 32'h1);
			// Event on the clearing edge itself: the flag must stay
			fork
				apb(1'b1, OFF_IRQ_STATUS, 32'h1 << pos[8-i]);
				begin
					repeat (2) @(posedge clk_sys);
					ev <= mac_events_s'(9'h001 << i);
					@(posedge clk_sys);
					ev <= '0;
				end
			join
			@(negedge clk_sys);
			check("set wins", 32'(irq), 32'h1);
			apb(1'b1, OFF_IRQ_STATUS, 32'h1 << pos[8-i]);
			@(negedge clk_sys);
			check("irq cleared", 32'(irq), 32'h0);
		end
		apb(1'b1, OFF_WATERMARKS, 32'h0010_0004);
		apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0300);
		apb(1'b1, OFF_CONTROL, 32'h0000_0001);
		set_cnt(8'h0f);
		check("full below", 32'(full_ev), 32'h0);
		check("flow below", 32'(fc_on), 32'h0);
		set_cnt(8'h10);
		check("full at", 32'(full_ev), 32'h1);
		check("flow on", 32'(fc_on), 32'h1);
		check("irq full", 32'(irq), 32'h1);
		set_cnt(8'h05);
		check("empty above", 32'(empty_ev), 32'h0);
		check("flow held", 32'(fc_on), 32'h1);
		set_cnt(8'h04);
		check("empty at", 32'(empty_ev), 32'h1);
		check("flow off", 32'(fc_on), 32'h0);
		rd(OFF_IRQ_STATUS, 32'h0000_0300, "level status");
		apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0200);
		@(negedge clk_sys);
		check("irq empty en", 32'(irq), 32'h1);
		apb(1'b1, OFF_IRQ_STATUS, 32'h0000_0200);
		@(negedge clk_sys);
		check("irq full masked", 32'(irq), 32'h0);
		set_cnt(8'h20);
		apb(1'b1, OFF_CONTROL, 32'h0000_0000);
		repeat (2) @(negedge clk_sys);
		check("flow manual", 32'(fc_on), 32'h0);
		// Second reset with registers written and the full level met
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		rd(OFF_WATERMARKS, RESET_WORD, "levels rerun");
		rd(OFF_IRQ_ENABLE, RESET_WORD, "enable rerun");
		check("full rerun", 32'(full_ev), 32'h0);
		check("irq rerun", 32'(irq), 32'h0);
		rd(8'h20, 32'h0000_0000, "unmapped data");
		check("unmapped err", 32'(e), 32'h1);
		give_verdict();
	end
endmodule : tb
